// ==== include/pesc_pkg.sv ====
// Shared constants and types for the program/erase suspend controller
package pesc_pkg;
    // Clock rate in kHz (125 MHz)
    localparam int CLK_KHZ = 125000;
    // Suspend latency limits in microseconds
    localparam int PGM_SUSP_LAT_US = 25;
    localparam int ERS_SUSP_LAT_US = 30;
    // Longest times round down to whole cycles
    localparam int PGM_SUSP_CYC = (PGM_SUSP_LAT_US * CLK_KHZ) / 1000;
    localparam int ERS_SUSP_CYC = (ERS_SUSP_LAT_US * CLK_KHZ) / 1000;
    localparam int CNT_W = 12;
    // Latency actually used: a fraction of the limit, well inside it
    localparam logic [CNT_W-1:0] PGM_SUSP_USE = CNT_W'(PGM_SUSP_CYC / 2);
    localparam logic [CNT_W-1:0] ERS_SUSP_USE = CNT_W'(ERS_SUSP_CYC / 2);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // Opcodes
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SUBSECTOR_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_SUBSECTOR_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
    localparam logic [7:0] OP_BULK_ERASE_ALT = 8'h60;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_NVCFG = 8'hb1;
    localparam logic [7:0] OP_PROGRAM_OTP = 8'h42;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_DUAL_READ = 8'h3b;
    localparam logic [7:0] OP_QUAD_READ = 8'h6b;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;

    // Operation classes
    typedef enum logic [2:0] {
        PESC_CLS_OTHER,
        PESC_CLS_PROGRAM,
        PESC_CLS_SUBSECTOR,
        PESC_CLS_SECTOR,
        PESC_CLS_BULK,
        PESC_CLS_READ,
        PESC_CLS_SUSPEND,
        PESC_CLS_RESUME
    } pesc_cls_t;
endpackage

// ==== rtl/pesc_decode.sv ====
// Opcode classifier and suspended-state command filter
`timescale 1ns/1ps
module pesc_decode (
    input wire logic [7:0] opcode_in,
    input wire logic prog_susp_in,
    input wire logic erase_susp_in,
    input wire logic sub_susp_in,
    output pesc_pkg::pesc_cls_t cls_out,
    output logic allow_out
);
    logic is_read;
    logic barred;

    // Map opcode to class; both bulk erase encodings decode alike
    always_comb begin
        is_read = 1'b0;
        case (opcode_in)
            pesc_pkg::OP_PAGE_PROGRAM: cls_out = pesc_pkg::PESC_CLS_PROGRAM;
            pesc_pkg::OP_SUBSECTOR_ERASE_4K,
            pesc_pkg::OP_SUBSECTOR_ERASE_32K: cls_out = pesc_pkg::PESC_CLS_SUBSECTOR;
            pesc_pkg::OP_SECTOR_ERASE: cls_out = pesc_pkg::PESC_CLS_SECTOR;
            pesc_pkg::OP_BULK_ERASE,
            pesc_pkg::OP_BULK_ERASE_ALT: cls_out = pesc_pkg::PESC_CLS_BULK;
            pesc_pkg::OP_SUSPEND: cls_out = pesc_pkg::PESC_CLS_SUSPEND;
            pesc_pkg::OP_RESUME: cls_out = pesc_pkg::PESC_CLS_RESUME;
            pesc_pkg::OP_READ,
            pesc_pkg::OP_FAST_READ,
            pesc_pkg::OP_DUAL_READ,
            pesc_pkg::OP_QUAD_READ,
            pesc_pkg::OP_READ_STATUS: begin
                cls_out = pesc_pkg::PESC_CLS_READ;
                is_read = 1'b1;
            end
            default: cls_out = pesc_pkg::PESC_CLS_OTHER;
        endcase
    end

    // Commands refused while an erase is suspended
    assign barred = (cls_out == pesc_pkg::PESC_CLS_SUBSECTOR)
        || (cls_out == pesc_pkg::PESC_CLS_SECTOR)
        || (cls_out == pesc_pkg::PESC_CLS_BULK)
        || (opcode_in == pesc_pkg::OP_WRITE_STATUS)
        || (opcode_in == pesc_pkg::OP_WRITE_NVCFG)
        || (opcode_in == pesc_pkg::OP_PROGRAM_OTP);

    // Program/subsector suspend: reads and resume only; erase suspend: all but barred
    always_comb begin
        if (prog_susp_in || sub_susp_in) begin
            allow_out = is_read || (cls_out == pesc_pkg::PESC_CLS_RESUME);
        end else if (erase_susp_in) begin
            allow_out = !barred;
        end else begin
            allow_out = 1'b1;
        end
    end
endmodule

// ==== rtl/pesc_ctrl.sv ====
// Program/erase suspend and resume sequencer
`timescale 1ns/1ps
// Behaviour
// - Suspended within 25 us for program, 30 us for subsector and sector erase; bulk erase is never suspended.
// - Any read accepted while program or subsector erase is suspended.
// - Erase suspended: all accepted except erases, suspend, status, nonvolatile config, OTP writes.
// - Opcode 60h decodes as bulk erase.
module pesc_ctrl (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic op_done_in,
    output logic cmd_accept_out,
    output logic cmd_reject_out,
    output logic [2:0] start_cls_out,
    output logic busy_out,
    output logic suspended_out,
    output logic engine_run_out
);
    typedef enum logic [2:0] {
        PESC_IDLE,
        PESC_RUN,
        PESC_SUSPENDING,
        PESC_SUSPENDED
    } pesc_state_t;

    pesc_state_t state, next_state;
    pesc_pkg::pesc_cls_t op_cls, next_op_cls;
    logic [pesc_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [pesc_pkg::CNT_W-1:0] lat_cnt, next_lat_cnt;
    logic next_accept, next_reject, next_susp, next_busy, next_run;
    logic [2:0] next_start_cls;
    pesc_pkg::pesc_cls_t cls;
    logic allow;
    logic ps, es, ss;

    // Which kind of operation is held in suspension
    assign ps = (state == PESC_SUSPENDED) && (op_cls == pesc_pkg::PESC_CLS_PROGRAM);
    assign ss = (state == PESC_SUSPENDED) && (op_cls == pesc_pkg::PESC_CLS_SUBSECTOR);
    assign es = (state == PESC_SUSPENDED) && (op_cls == pesc_pkg::PESC_CLS_SECTOR);

    pesc_decode i_pesc_decode (
        .opcode_in(opcode_in),
        .prog_susp_in(ps),
        .erase_susp_in(es),
        .sub_susp_in(ss),
        .cls_out(cls),
        .allow_out(allow)
    );

    function automatic logic is_long_op(input pesc_pkg::pesc_cls_t c);
        is_long_op = (c == pesc_pkg::PESC_CLS_PROGRAM) || (c == pesc_pkg::PESC_CLS_SUBSECTOR)
            || (c == pesc_pkg::PESC_CLS_SECTOR) || (c == pesc_pkg::PESC_CLS_BULK);
    endfunction

    // Next-state logic; suspend is honoured at any time in a run except bulk erase or a cycle with op_done_in, no run interval is checked
    always_comb begin
        next_state = state;
        next_op_cls = op_cls;
        next_cnt = cnt;
        next_accept = 1'b0;
        next_reject = 1'b0;
        next_start_cls = pesc_pkg::PESC_CLS_OTHER;
        case (state)
            PESC_IDLE: begin
                if (cmd_valid_in) begin
                    next_accept = 1'b1;
                    next_start_cls = cls;
                    if (is_long_op(cls)) begin
                        next_state = PESC_RUN;
                        next_op_cls = cls;
                    end
                end
            end
            PESC_RUN: begin
                if (op_done_in) begin
                    next_state = PESC_IDLE;
                end else if (cmd_valid_in && cls == pesc_pkg::PESC_CLS_SUSPEND
                             && op_cls != pesc_pkg::PESC_CLS_BULK) begin
                    next_accept = 1'b1;
                    next_state = PESC_SUSPENDING;
                    next_cnt = (op_cls == pesc_pkg::PESC_CLS_PROGRAM)
                        ? pesc_pkg::PGM_SUSP_USE : pesc_pkg::ERS_SUSP_USE;
                end else if (cmd_valid_in) begin
                    next_reject = 1'b1;
                end
            end
            PESC_SUSPENDING: begin
                if (cmd_valid_in) begin
                    next_reject = 1'b1;
                end
                if (cnt == pesc_pkg::CNT_ONE) begin
                    next_state = PESC_SUSPENDED;
                    next_cnt = pesc_pkg::CNT_ZERO;
                end else begin
                    next_cnt = cnt - pesc_pkg::CNT_ONE;
                end
            end
            PESC_SUSPENDED: begin
                if (cmd_valid_in) begin
                    if (cls == pesc_pkg::PESC_CLS_RESUME) begin
                        next_accept = 1'b1;
                        next_state = PESC_RUN;
                    end else if (allow && cls != pesc_pkg::PESC_CLS_SUSPEND) begin
                        // A program is taken in erase suspend too; the held erase stays held
                        next_accept = 1'b1;
                        next_start_cls = cls;
                    end else begin
                        next_reject = 1'b1;
                    end
                end
            end
            default: next_state = PESC_IDLE;
        endcase
        next_susp = (next_state == PESC_SUSPENDED);
        next_busy = (next_state != PESC_IDLE);
        next_run = (next_state == PESC_RUN) || (next_state == PESC_SUSPENDING);
        // Cycles spent in the latency phase; lets the latency check stay a plain compare
        next_lat_cnt = (state == PESC_SUSPENDING) ? lat_cnt + pesc_pkg::CNT_ONE
            : pesc_pkg::CNT_ZERO;
    end

    // Register all state and outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= PESC_IDLE;
            op_cls <= pesc_pkg::PESC_CLS_OTHER;
            cnt <= pesc_pkg::CNT_ZERO;
            lat_cnt <= pesc_pkg::CNT_ZERO;
            cmd_accept_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            start_cls_out <= 3'h0;
            suspended_out <= 1'b0;
            busy_out <= 1'b0;
            engine_run_out <= 1'b0;
        end else begin
            state <= next_state;
            op_cls <= next_op_cls;
            cnt <= next_cnt;
            lat_cnt <= next_lat_cnt;
            cmd_accept_out <= next_accept;
            cmd_reject_out <= next_reject;
            start_cls_out <= next_start_cls;
            suspended_out <= next_susp;
            busy_out <= next_busy;
            engine_run_out <= next_run;
        end
    end

    // Checks
    chk_susp_latency: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == PESC_SUSPENDING)
        |-> ((op_cls == pesc_pkg::PESC_CLS_PROGRAM) ? (lat_cnt < pesc_pkg::PGM_SUSP_CYC)
            : (lat_cnt < pesc_pkg::ERS_SUSP_CYC)))
        else $error("suspend latency exceeded");
    chk_flag_matches: assert property (@(posedge clk_in) disable iff (!rstn_in)
        suspended_out == (state == PESC_SUSPENDED))
        else $error("suspended flag out of step");
    chk_resume_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == PESC_SUSPENDED && cmd_valid_in && cls == pesc_pkg::PESC_CLS_RESUME)
        |=> !suspended_out && cmd_accept_out && engine_run_out)
        else $error("resume did not clear suspension");
    chk_read_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == PESC_SUSPENDED && cmd_valid_in && cls == pesc_pkg::PESC_CLS_READ)
        |=> cmd_accept_out && suspended_out)
        else $error("read refused while suspended");
    chk_erase_barred: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (es && cmd_valid_in && (opcode_in == pesc_pkg::OP_WRITE_STATUS
         || cls == pesc_pkg::PESC_CLS_BULK || cls == pesc_pkg::PESC_CLS_SECTOR))
        |=> cmd_reject_out && !cmd_accept_out)
        else $error("barred command accepted in erase suspend");
    chk_bulk_alt: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == PESC_IDLE && cmd_valid_in && opcode_in == pesc_pkg::OP_BULK_ERASE_ALT)
        |=> start_cls_out == 3'(pesc_pkg::PESC_CLS_BULK) && busy_out)
        else $error("alternate bulk erase not decoded");
    chk_no_interval: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == PESC_RUN && !op_done_in && cmd_valid_in
         && cls == pesc_pkg::PESC_CLS_SUSPEND && op_cls != pesc_pkg::PESC_CLS_BULK)
        |=> !suspended_out ##1 state == PESC_SUSPENDING)
        else $error("suspend not taken at once");
    chk_suspend_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(suspended_out) |-> $past(state) == PESC_SUSPENDING)
        else $error("suspension without latency phase");
    cov_prog_susp: cover property (@(posedge clk_in) disable iff (!rstn_in) ps);
    cov_erase_susp: cover property (@(posedge clk_in) disable iff (!rstn_in) es);
    cov_sub_susp: cover property (@(posedge clk_in) disable iff (!rstn_in) ss);
    cov_resume: cover property (@(posedge clk_in) disable iff (!rstn_in) $fell(suspended_out));
endmodule

// ==== verification/pesc_host_model.sv ====
// Host-side command issuer facing the suspend controller
`timescale 1ns/1ps
module pesc_host_model (
    input wire logic clk_in,
    input wire logic accept_in,
    input wire logic reject_in,
    output logic cmd_valid_out,
    output logic [7:0] opcode_out
);
    initial begin
        cmd_valid_out = 1'b0;
        opcode_out = 8'h00;
    end

    // One command held across one rising edge; the answer is gathered over two cycles
    task automatic issue(input logic [7:0] op, output logic took, output logic refused);
        took = 1'b0;
        refused = 1'b0;
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        opcode_out = op;
        repeat (2) begin
            @(negedge clk_in);
            cmd_valid_out = 1'b0;
            opcode_out = ~op; // Released bus never shows a stale opcode
            took = took | accept_in;
            refused = refused | reject_in;
        end
    endtask

    // The device does not time run intervals, so the host sits them out itself
    task automatic run_for(input int us);
        repeat (us * 125) @(negedge clk_in);
    endtask
endmodule

// ==== verification/pesc_ctrl_tb.sv ====
// Self-checking bench for the suspend controller
`timescale 1ns/1ps
module pesc_ctrl_tb;
    logic clk_in, rstn_in, cmd_valid_in, op_done_in, took, refused;
    logic [7:0] opcode_in;
    logic [2:0] start_cls_out, last_cls;
    logic cmd_accept_out, cmd_reject_out, busy_out, suspended_out, engine_run_out;
    int failures = 0;
    int comparisons = 0;
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

    pesc_ctrl i_pesc_ctrl (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
        .opcode_in(opcode_in), .op_done_in(op_done_in), .cmd_accept_out(cmd_accept_out),
        .cmd_reject_out(cmd_reject_out), .start_cls_out(start_cls_out), .busy_out(busy_out),
        .suspended_out(suspended_out), .engine_run_out(engine_run_out));
    pesc_host_model i_pesc_host_model (.clk_in(clk_in), .accept_in(cmd_accept_out),
        .reject_in(cmd_reject_out), .cmd_valid_out(cmd_valid_in), .opcode_out(opcode_in));

    // Class is only valid in the accept cycle, so latch it there
    always @(posedge clk_in) if (cmd_accept_out === 1'b1) last_cls <= start_cls_out;

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    task automatic stop_test();
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Issue one command and judge accept against refuse
    task automatic cmd(input logic [7:0] op, input logic acc);
        i_pesc_host_model.issue(op, took, refused);
        `CHK("accept", acc, took)
        `CHK("reject", ~acc, refused)
    endtask

    // Suspend, then bound the time until the flag shows
    task automatic susp(input int limit);
        int n;
        n = 0;
        cmd(pesc_pkg::OP_SUSPEND, 1'b1);
        `CHK("early_flag", 1'b0, suspended_out)
        while (suspended_out !== 1'b1 && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        `CHK("latency_ok", 1'b1, n <= limit)
        `CHK("engine_halt", 1'b0, engine_run_out)
    endtask

    task automatic resume();
        cmd(pesc_pkg::OP_RESUME, 1'b1);
        `CHK("flag_clear", 1'b0, suspended_out)
        `CHK("engine_run", 1'b1, engine_run_out)
    endtask

    task automatic finish_op();
        @(negedge clk_in);
        op_done_in = 1'b1;
        @(negedge clk_in);
        op_done_in = 1'b0;
        @(negedge clk_in);
        `CHK("busy_end", 1'b0, busy_out)
    endtask

    task automatic t_sector();
        logic [7:0] bad [7] = '{8'hd8, 8'h20, 8'h52, 8'hc7, 8'h60, 8'h01, 8'hb1};
        cmd(pesc_pkg::OP_SECTOR_ERASE, 1'b1);
        `CHK("cls_sector", 3'h3, last_cls)
        `CHK("busy", 1'b1, busy_out)
        i_pesc_host_model.run_for(150);
        susp(pesc_pkg::ERS_SUSP_CYC);
        foreach (bad[i]) cmd(bad[i], 1'b0);
        cmd(pesc_pkg::OP_PROGRAM_OTP, 1'b0);
        cmd(pesc_pkg::OP_READ_STATUS, 1'b1);
        cmd(pesc_pkg::OP_QUAD_READ, 1'b1);
        cmd(pesc_pkg::OP_PAGE_PROGRAM, 1'b1);
        resume();
        finish_op();
    endtask

    task automatic t_subsector();
        logic [7:0] rd [5] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'h05};
        cmd(pesc_pkg::OP_SUBSECTOR_ERASE_32K, 1'b1);
        `CHK("cls_sub", 3'h2, last_cls)
        i_pesc_host_model.run_for(50);
        susp(pesc_pkg::ERS_SUSP_CYC);
        foreach (rd[i]) cmd(rd[i], 1'b1);
        cmd(pesc_pkg::OP_SECTOR_ERASE, 1'b0);
        resume();
        finish_op();
    endtask

    task automatic t_program();
        cmd(pesc_pkg::OP_PAGE_PROGRAM, 1'b1);
        `CHK("cls_prog", 3'h1, last_cls)
        susp(pesc_pkg::PGM_SUSP_CYC);
        cmd(pesc_pkg::OP_FAST_READ, 1'b1);
        cmd(pesc_pkg::OP_SECTOR_ERASE, 1'b0);
        resume();
        i_pesc_host_model.run_for(5);
        susp(pesc_pkg::PGM_SUSP_CYC);
        resume();
        finish_op();
    endtask

    task automatic t_bulk_alt();
        cmd(pesc_pkg::OP_BULK_ERASE_ALT, 1'b1);
        `CHK("cls_bulk", 3'h4, last_cls)
        cmd(pesc_pkg::OP_SUSPEND, 1'b0);
        finish_op();
    endtask

    // Watchdog well beyond the longest expected run
    initial begin
        #600000;
        failures++;
        stop_test();
    end

    initial begin
        rstn_in = 1'b0;
        op_done_in = 1'b0;
        repeat (20) @(negedge clk_in);
        // Command strobe sits idle long before reset lets go
        rstn_in = 1'b1;
        `CHK("busy_rst", 1'b0, busy_out)
        t_sector();
        t_subsector();
        t_program();
        t_bulk_alt();
        stop_test();
    end
endmodule
